/* File: tcp_chan.sv */
package tcp_pkg;
    localparam int CH_N = 4;
    localparam int CNT_W = 16;
    localparam logic [7:0] OFS_TSC = 8'h00;
    localparam logic [7:0] OFS_CNT = 8'h04;
    localparam logic [7:0] OFS_MOD = 8'h08;
    localparam logic [7:0] OFS_CH_BASE = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h08;
    localparam logic [7:0] CH_VAL_OFS = 8'h04;
    localparam logic [15:0] MOD_RST = 16'hffff;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [7:0] CS_RST = 8'h00;
    localparam int TSC_RUN = 0;
    localparam int TSC_TOIE = 1;
    localparam int TSC_TRST = 2;
    localparam int TSC_TOF = 7;
    localparam int CS_FLAG = 7;
    localparam int CS_IE = 6;
    localparam int CS_MSB = 5;
    localparam int CS_MSA = 4;
    localparam int CS_ELSB = 3;
    localparam int CS_ELSA = 2;
    localparam int CS_TOV = 1;
    localparam int CS_MAX = 0;
    localparam logic [1:0] ELS_OFF = 2'b00;
    localparam logic [1:0] ELS_TOGGLE = 2'b01;
    localparam logic [1:0] ELS_CLEAR = 2'b10;
    localparam logic [1:0] ELS_SET = 2'b11;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

module tcp_chan (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic ovf,
    input wire logic [tcp_pkg::CNT_W-1:0] cnt,
    input wire logic [tcp_pkg::CNT_W-1:0] cmp_val,
    input wire logic oc_mode,
    input wire logic [1:0] els,
    input wire logic tov,
    input wire logic max_duty,
    input wire logic drive_en,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic capture,
    output logic match
);
    import tcp_pkg::*;

    logic sync1_q, sync2_q, prev_q, pin_q;
    logic rise, fall;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;
    // els 01 rising, 10 falling, 11 both, 00 capture off
    assign capture = ce & ~oc_mode & ((els[0] & rise) | (els[1] & fall));
    assign match = ce & oc_mode & tick & (cnt == cmp_val);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= 1'b0;
        end else if (ce && oc_mode) begin
            if (max_duty) begin
                // forced to the pulse level: complement of the compare action
                pin_q <= (els == ELS_CLEAR);
            end else if (match) begin
                // compare wins over the overflow toggle when both land together
                unique case (els)
                    ELS_TOGGLE: pin_q <= ~pin_q;
                    ELS_CLEAR: pin_q <= 1'b0;
                    ELS_SET: pin_q <= 1'b1;
                    ELS_OFF: pin_q <= pin_q;
                endcase
            end else if (ovf && tov) begin
                pin_q <= ~pin_q;
            end
        end
    end

    assign pin_o = pin_q;
    assign pin_oe = oc_mode & drive_en & (els != ELS_OFF);

    clear_act_a: assert property (@(posedge aclk) disable iff (!aresetn)
        match && els == ELS_CLEAR && !max_duty |=> !pin_o)
        else $error("compare clear did not drive pin low");
    max_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && oc_mode && max_duty && els == ELS_CLEAR |=> pin_o)
        else $error("max duty did not hold pin at pulse level");
endmodule

/* File: tcp_pin_model.sv */
module tcp_pin_model (
    input wire logic [tcp_pkg::CH_N-1:0] pin_o,
    input wire logic [tcp_pkg::CH_N-1:0] pin_oe,
    input wire logic [tcp_pkg::CH_N-1:0] src_lvl,
    output logic [tcp_pkg::CH_N-1:0] pin_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import tcp_pkg::*;
    // a driven pin wins, a released one shows the outside event source
    always_comb begin
        for (int i = 0; i < CH_N; i++) begin
            pin_i[i] = pin_oe[i] ? pin_o[i] : src_lvl[i];
        end
    end
endmodule

/* File: tcp_timer.sv */
// Function
// - on an active pin edge in capture mode, copy the counter into the value
// - software picks the active edge polarity per capture channel
// - a capture can raise a channel interrupt request
// - on compare match set, clear or toggle the pin as configured
// - a compare match can raise a channel interrupt request
// - unbuffered value writes take effect at once; passed values miss
// - compare request ends the pulse, overflow request ends the period
// - channel 0 link bit joins channels 0 and 1 onto pin 0
// - channel 2 link bit joins channels 2 and 3 onto pin 2
// - written inactive set takes control at the next overflow
// - linked: even register controls pair, odd ignored, odd pin released
// - toggle-on-overflow flips the pin when the counter rolls over from modulo
// - modulo 255 undivided gives a 256 clock PWM period
// - with 8-bit period, value 128 gives 50 percent duty
// - mode 01 unbuffered, 10 buffered; edge 10 clears, 11 sets
// - the link bit overrides the lower mode bit of that channel
// - no toggle gives 0 percent; max bit without toggle gives 100 percent
// - overflow flag sets when the counter rolls over from modulo
module tcp_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [tcp_pkg::CH_N-1:0] pin_i,
    output logic [tcp_pkg::CH_N-1:0] pin_o,
    output logic [tcp_pkg::CH_N-1:0] pin_oe,
    output logic [tcp_pkg::CH_N-1:0] irq_ch,
    output logic irq_ovf
);
    import tcp_pkg::*;

    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    function automatic logic [7:0] cs_ofs(input int i);
        cs_ofs = 8'(OFS_CH_BASE + CH_STRIDE * i);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] lo;
        lo = a[7:0];
        mapped = ((a >> 8) == '0) && (lo[1:0] == 2'b00)
            && (lo == OFS_TSC || lo == OFS_CNT || lo == OFS_MOD
            || (lo >= OFS_CH_BASE && lo < cs_ofs(CH_N)));
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, rd_d;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q, rresp_d;
    logic wr_fire, wr_map, wr_tsc, wr_mod;
    logic [7:0] wa, ra;
    logic [CH_N-1:0] wr_cs, wr_val;

    logic run_q, toie_q, tof_q;
    logic [CNT_W-1:0] cnt_q, mod_q, cnt_nx;
    logic tick, ovf;
    logic [7:0] cs_q [CH_N];
    logic [CNT_W-1:0] val_q [CH_N];
    logic [CNT_W-1:0] cmp [CH_N];
    logic [1:0] ch_els [CH_N];
    logic [CH_N-1:0] oc, drv, cap, mt;
    logic [CH_N/2-1:0] pend_q, act_q, link;

    // write channel: address and data taken independently, any order
    assign awready = ce & ~aw_have_q;
    assign wready = ce & ~w_have_q;
    assign wr_fire = ce & aw_have_q & w_have_q & ~bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (ce) begin
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_map ? RESP_OKAY : RESP_DECERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    always_comb begin
        wa = awaddr_q[7:0];
        wr_map = mapped(awaddr_q);
        wr_tsc = wr_fire & wr_map & (wa == OFS_TSC) & wstrb_q[0];
        wr_mod = wr_fire & wr_map & (wa == OFS_MOD);
        for (int i = 0; i < CH_N; i++) begin
            wr_cs[i] = wr_fire & wr_map & (wa == cs_ofs(i)) & wstrb_q[0];
            wr_val[i] = wr_fire & wr_map & (wa == cs_ofs(i) + CH_VAL_OFS);
        end
    end

    // counter, modulo and overflow; no prescaler, one count per enabled clock
    assign tick = ce & run_q;
    assign ovf = tick & (cnt_q == mod_q);
    // compares see the count about to be taken, so the pin moves as it arrives
    assign cnt_nx = ovf ? '0 : cnt_q + CNT_W'(1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            toie_q <= 1'b0;
            tof_q <= 1'b0;
            cnt_q <= '0;
            mod_q <= MOD_RST;
        end else if (ce) begin
            if (wr_tsc && wdata_q[TSC_TRST]) begin
                cnt_q <= '0;
            end else if (tick) begin
                cnt_q <= cnt_nx;
            end
            // set wins over a clear-by-writing-zero in the same cycle
            tof_q <= ovf | (tof_q & ~(wr_tsc & ~wdata_q[TSC_TOF]));
            if (wr_tsc) begin
                run_q <= wdata_q[TSC_RUN];
                toie_q <= wdata_q[TSC_TOIE];
            end
            if (wr_mod) begin
                mod_q <= merge16(mod_q, wdata_q, wstrb_q);
            end
        end
    end

    assign irq_ovf = tof_q & toie_q;

    // channel control/status and value registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < CH_N; i++) begin
                cs_q[i] <= CS_RST;
                val_q[i] <= VAL_RST;
            end
        end else if (ce) begin
            for (int i = 0; i < CH_N; i++) begin
                if (wr_cs[i]) begin
                    cs_q[i][6:0] <= wdata_q[6:0];
                    // link bit exists on even channels only
                    if (i % 2 == 1) begin
                        cs_q[i][CS_MSB] <= 1'b0;
                    end
                end
                cs_q[i][CS_FLAG] <= cap[i] | mt[i]
                    | (cs_q[i][CS_FLAG] & ~(wr_cs[i] & ~wdata_q[CS_FLAG]));
                if (cap[i]) begin
                    val_q[i] <= cnt_q;
                end else if (wr_val[i]) begin
                    val_q[i] <= merge16(val_q[i], wdata_q, wstrb_q);
                end
            end
        end
    end

    // pair buffering: last written set takes over at overflow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= '0;
            act_q <= '0;
        end else if (ce) begin
            for (int p = 0; p < CH_N / 2; p++) begin
                if (!link[p]) begin
                    pend_q[p] <= 1'b0;
                    act_q[p] <= 1'b0;
                end else begin
                    if (wr_val[2*p+1]) begin
                        pend_q[p] <= 1'b1;
                    end else if (wr_val[2*p]) begin
                        pend_q[p] <= 1'b0;
                    end
                    if (ovf) begin
                        act_q[p] <= pend_q[p];
                    end
                end
            end
        end
    end

    for (genvar i = 0; i < CH_N; i++) begin : g_ch
        localparam int EV = i - i % 2;
        localparam bit ODD = (i % 2 == 1);
        if (!ODD) begin : g_link
            assign link[i/2] = cs_q[i][CS_MSB];
        end
        // odd channel of a linked pair goes idle and releases its pin
        assign oc[i] = ODD ? cs_q[i][CS_MSA] & ~link[i/2]
                           : link[i/2] | cs_q[i][CS_MSA];
        assign ch_els[i] = (ODD && link[i/2]) ? ELS_OFF : cs_q[i][CS_ELSB:CS_ELSA];
        assign drv[i] = !(ODD && link[i/2]);
        assign cmp[i] = (!ODD && link[i/2] && act_q[i/2]) ? val_q[EV+1] : val_q[i];
        assign irq_ch[i] = cs_q[i][CS_FLAG] & cs_q[i][CS_IE];

        tcp_chan u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .tick(tick),
            .ovf(ovf),
            .cnt(cnt_nx),
            .cmp_val(cmp[i]),
            .oc_mode(oc[i]),
            .els(ch_els[i]),
            .tov(cs_q[i][CS_TOV] & (ODD ? ~link[i/2] : 1'b1)),
            .max_duty(cs_q[i][CS_MAX] & ~cs_q[i][CS_TOV]),
            .drive_en(drv[i]),
            .pin_i(pin_i[i]),
            .pin_o(pin_o[i]),
            .pin_oe(pin_oe[i]),
            .capture(cap[i]),
            .match(mt[i])
        );
    end

    // read channel, one outstanding read, data registered
    assign arready = ce & ~rvalid_q;

    always_comb begin
        ra = araddr[7:0];
        rd_d = '0;
        rresp_d = RESP_OKAY;
        if (!mapped(araddr)) begin
            rresp_d = RESP_DECERR;
        end else if (ra == OFS_TSC) begin
            rd_d[TSC_TOF] = tof_q;
            rd_d[TSC_TOIE] = toie_q;
            rd_d[TSC_RUN] = run_q;
        end else if (ra == OFS_CNT) begin
            rd_d[15:0] = cnt_q;
        end else if (ra == OFS_MOD) begin
            rd_d[15:0] = mod_q;
        end else begin
            for (int i = 0; i < CH_N; i++) begin
                if (ra == cs_ofs(i)) begin
                    rd_d[7:0] = cs_q[i];
                end
                if (ra == cs_ofs(i) + CH_VAL_OFS) begin
                    rd_d[15:0] = val_q[i];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_d;
                rresp_q <= rresp_d;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    cap_copy_a: assert property (cap[1] |=> val_q[1] == $past(cnt_q))
        else $error("capture did not latch counter");
    cap_flag_a: assert property (cap[1] |=> cs_q[1][CS_FLAG])
        else $error("capture did not set event flag");
    cmp_flag_a: assert property (mt[0] |=> cs_q[0][CS_FLAG])
        else $error("compare did not set event flag");
    irq_gate_a: assert property (mt[0] && cs_q[0][CS_IE] && !wr_cs[0] |=> irq_ch[0])
        else $error("enabled compare raised no channel request");
    tof_set_a: assert property (ovf |=> tof_q && cnt_q == '0)
        else $error("overflow did not set flag and wrap");
    link_rel_a: assert property (link[0] |-> !pin_oe[1] && oc[0])
        else $error("linked pair did not release odd pin");
    swap_set_a: assert property (ovf && link[1] |=> act_q[1] == $past(pend_q[1]))
        else $error("linked pair did not swap at overflow");
    unbuf_wr_a: assert property (wr_val[2] && !cap[2] && wstrb_q == 4'hf
        |=> val_q[2] == $past(wdata_q[15:0]))
        else $error("unbuffered write not applied at once");
endmodule

/* File: tcp_timer_tb_top.sv */
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tcp_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tcp_pkg::*;
    localparam logic [31:0] RUN_B = 32'h1 << TSC_RUN;
    localparam logic [31:0] TRST_B = 32'h1 << TSC_TRST;
    localparam logic [31:0] TOIE_B = 32'h1 << TSC_TOIE;
    localparam logic [1:0] OC_ELS [3] = '{ELS_SET, ELS_CLEAR, ELS_TOGGLE};
    logic aclk, aresetn, ce;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq_ovf;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [CH_N-1:0] pin_i, pin_o, pin_oe, irq_ch, src_lvl;
    logic [4:0] irqs;
    int err_total, num_checks;
    assign irqs = {irq_ovf, irq_ch};

    tcp_timer dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .irq_ch(irq_ch),
        .irq_ovf(irq_ovf));
    tcp_pin_model pins_u (.pin_o(pin_o), .pin_oe(pin_oe), .src_lvl(src_lvl),
        .pin_i(pin_i));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // every polling wait (wr, rd, wsig, wl) goes through here so a hang ends the run
    task automatic bump(inout int n);
        n++;
        if (n > 5000) begin
            err_total++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            bump(n);
        end while (bvalid !== 1'b1);
        `CHK(bresp, er)
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            bump(n);
        end while (rvalid !== 1'b1);
        d = rdata;
        `CHK(rresp, er)
        rready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d, RESP_OKAY);
        `CHK(d, e)
    endtask

    task automatic wsig(input int k);
        int n;
        n = 0;
        while (irqs[k] !== 1'b1) begin
            @(posedge aclk);
            bump(n);
        end
    endtask

    task automatic wl(input int p, input logic l, output int n);
        n = 0;
        while (pin_o[p] !== l) begin
            @(posedge aclk);
            bump(n);
        end
    endtask

    // one full pulse and period, starting at the next rising edge
    task automatic meas(input int p, output int hi, output int per);
        int n;
        int lo;
        wl(p, 1'b0, n);
        wl(p, 1'b1, n);
        wl(p, 1'b0, hi);
        wl(p, 1'b1, lo);
        per = hi + lo;
    endtask

    function automatic logic [7:0] ca(input int i, input bit v);
        return OFS_CH_BASE + CH_STRIDE * 8'(i) + (v ? CH_VAL_OFS : 8'h00);
    endfunction

    function automatic logic [31:0] ctl(input bit ie, lk, ml, input logic [1:0] e,
                                        input bit tv, mx);
        return (32'(ie) << CS_IE) | (32'(lk) << CS_MSB) | (32'(ml) << CS_MSA)
            | (32'(e) << CS_ELSA) | (32'(tv) << CS_TOV) | (32'(mx) << CS_MAX);
    endfunction

    initial begin
        logic [31:0] d;
        logic [31:0] c;
        logic ep;
        int hi, per, v, cur, bad;
        void'($urandom(32'hfb597095));
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        ce = 1'b1;
        {awaddr, araddr, wdata, src_lvl} = '0;
        wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(OFS_TSC, 32'h0);
        rdc(OFS_MOD, 32'(MOD_RST));
        rdc(OFS_CNT, 32'h0);
        for (int i = 0; i < CH_N; i++) begin
            rdc(ca(i, 0), 32'(CS_RST));
        end
        `CHK({pin_oe, irqs}, 9'h000)
        rd(8'hfc, d, RESP_DECERR);
        wr(8'hfc, 32'h1, RESP_DECERR);
        // capture: ch1 on rising with request, ch3 on falling without
        wr(ca(1, 0), ctl(1, 0, 0, 2'b01, 0, 0), RESP_OKAY);
        wr(ca(3, 0), ctl(0, 0, 0, 2'b10, 0, 0), RESP_OKAY);
        wr(OFS_TSC, RUN_B | TRST_B, RESP_OKAY);
        repeat ($urandom_range(100, 20)) @(posedge aclk);
        rd(OFS_CNT, c, RESP_OKAY);
        src_lvl <= 4'ha;
        repeat (10) @(posedge aclk);
        rd(ca(1, 1), d, RESP_OKAY);
        `CHK((d - c) < 32'h10, 1'b1)
        `CHK(irqs[1], 1'b1)
        rd(ca(3, 0), d, RESP_OKAY);
        `CHK(d[CS_FLAG], 1'b0)
        src_lvl <= 4'h0;
        repeat (10) @(posedge aclk);
        rd(ca(3, 0), d, RESP_OKAY);
        `CHK(d[CS_FLAG], 1'b1)
        `CHK(irqs[3], 1'b0)
        wr(ca(1, 0), 32'h0, RESP_OKAY);
        wr(ca(3, 0), 32'h0, RESP_OKAY);
        // compare actions, one fresh count each
        ep = 1'b0;
        for (int k = 0; k < 3; k++) begin
            v = $urandom_range(255, 64);
            wr(OFS_TSC, TRST_B, RESP_OKAY);
            wr(ca(0, 1), 32'(v), RESP_OKAY);
            wr(ca(0, 0), ctl(1, 0, 1, OC_ELS[k], 0, 0), RESP_OKAY);
            wr(OFS_TSC, RUN_B, RESP_OKAY);
            wsig(0);
            repeat (2) @(posedge aclk);
            ep = (OC_ELS[k] == ELS_SET) ? 1'b1 : (OC_ELS[k] == ELS_CLEAR) ? 1'b0 : ~ep;
            `CHK(pin_o[0], ep)
            `CHK(pin_oe[0], 1'b1)
            rd(OFS_CNT, c, RESP_OKAY);
            `CHK((c - 32'(v)) < 32'h10, 1'b1)
        end
        // a value moved behind the count misses this period
        wr(OFS_TSC, TRST_B, RESP_OKAY);
        wr(ca(0, 1), 32'h8000, RESP_OKAY);
        wr(ca(0, 0), ctl(0, 0, 1, ELS_CLEAR, 0, 0), RESP_OKAY);
        wr(OFS_TSC, RUN_B, RESP_OKAY);
        repeat (300) @(posedge aclk);
        wr(ca(0, 1), 32'h10, RESP_OKAY);
        repeat (400) @(posedge aclk);
        rd(ca(0, 0), d, RESP_OKAY);
        `CHK(d[CS_FLAG], 1'b0)
        `CHK(pin_o[0], 1'b1)
        // unbuffered pwm on ch2
        wr(OFS_TSC, TRST_B, RESP_OKAY);
        wr(OFS_MOD, 32'hff, RESP_OKAY);
        wr(ca(2, 1), 32'h80, RESP_OKAY);
        wr(ca(2, 0), ctl(1, 0, 1, ELS_CLEAR, 1, 0), RESP_OKAY);
        wr(OFS_TSC, RUN_B | TOIE_B, RESP_OKAY);
        meas(2, hi, per);
        `CHK(per, 32'h100)
        `CHK(hi, 32'h80)
        wr(ca(2, 0), ctl(1, 0, 1, ELS_CLEAR, 1, 0), RESP_OKAY);
        wsig(2);
        repeat (2) @(posedge aclk);
        `CHK(pin_o[2], 1'b0)
        wr(OFS_TSC, RUN_B | TOIE_B, RESP_OKAY);
        wsig(4);
        repeat (2) @(posedge aclk);
        `CHK(pin_o[2], 1'b1)
        cur = 128;
        repeat (3) begin
            v = $urandom_range(250, 8);
            wr(ca(2, 0), ctl(1, 0, 1, ELS_CLEAR, 1, 0), RESP_OKAY);
            wr(OFS_TSC, RUN_B | TOIE_B, RESP_OKAY);
            if (v > cur) begin
                wsig(4);
            end else begin
                wsig(2);
            end
            wr(ca(2, 1), 32'(v), RESP_OKAY);
            meas(2, hi, per);
            `CHK(hi, v)
            cur = v;
        end
        // no toggle holds low, max bit holds high
        for (int mx = 0; mx < 2; mx++) begin
            wr(ca(2, 0), ctl(0, 0, 1, ELS_CLEAR, 0, mx[0]), RESP_OKAY);
            repeat (mx ? 4 : 260) @(posedge aclk);
            bad = 0;
            repeat (300) begin
                @(posedge aclk);
                if (pin_o[2] !== mx[0]) bad++;
            end
            `CHK(bad, 0)
        end
        // linked pairs; mode low bit also set to show the link wins
        for (int p = 0; p < CH_N; p += 2) begin
            wr(OFS_TSC, TRST_B, RESP_OKAY);
            wr(ca(p, 1), 32'h40, RESP_OKAY);
            wr(ca(p, 0), ctl(0, 1, 1, ELS_CLEAR, 1, 0), RESP_OKAY);
            wr(OFS_TSC, RUN_B, RESP_OKAY);
            meas(p, hi, per);
            `CHK(hi, 32'h40)
            wr(ca(p + 1, 0), ctl(0, 0, 1, ELS_SET, 1, 0), RESP_OKAY);
            wr(ca(p + 1, 1), 32'h20, RESP_OKAY);
            meas(p, hi, per);
            `CHK(hi, 32'h20)
            `CHK(pin_oe[p + 1], 1'b0)
            wr(ca(p, 1), 32'h60, RESP_OKAY);
            meas(p, hi, per);
            `CHK(hi, 32'h60)
            rd(ca(p, 0), d, RESP_OKAY);
            `CHK(d[CS_FLAG], 1'b1)
            wr(ca(p + 1, 0), 32'h0, RESP_OKAY);
            wr(ca(p, 0), 32'h0, RESP_OKAY);
        end
        // clock enable low must freeze the count
        wr(OFS_MOD, 32'hffff, RESP_OKAY);
        wr(OFS_TSC, RUN_B | TRST_B, RESP_OKAY);
        rd(OFS_CNT, c, RESP_OKAY);
        ce <= 1'b0;
        repeat (40) @(posedge aclk);
        ce <= 1'b1;
        rd(OFS_CNT, d, RESP_OKAY);
        `CHK((d - c) < 32'h10, 1'b1)
        stop_test();
    end
endmodule
